/* core/mcm_defs.svh */
// Constants of the motor channel manager: widths, offsets, fields, reset values
`ifndef MCM_DEFS_SVH
`define MCM_DEFS_SVH

// Widths
`define MCM_AW              4
`define MCM_DW              8
`define MCM_NCH             6

// Register offsets
`define MCM_OFF_PHASE       4'h0
`define MCM_OFF_POLARITY    4'h1
`define MCM_OFF_GROUP       4'h2
`define MCM_OFF_CTRL_A      4'h3
`define MCM_OFF_CTRL_B      4'h4
`define MCM_OFF_INT_MASK    4'h5
`define MCM_OFF_INT_STATUS  4'h6
`define MCM_OFF_PHASE_ACT   4'h7

// Field positions
`define MCM_CRA_ENABLE      0
`define MCM_CRA_DIRECT      1
`define MCM_CRB_AFTERZ      0
`define MCM_CRB_WAITZ       1
`define MCM_CRB_DEMAG       2
`define MCM_INT_EMERG       0
`define MCM_INT_COMM        1

// Reset values
`define MCM_RST_PHASE       6'h00
`define MCM_RST_POLARITY    6'h00
`define MCM_RST_GROUP       6'h00
`define MCM_RST_OS          3'h0
`define MCM_RST_INT         2'h0
`define MCM_ALL_ONE6        6'h3f
`define MCM_ZERO_DW         8'h00

// Output reset-state option codes
`define MCM_OPT_HIZ         2'h0
`define MCM_OPT_LOW         2'h1
`define MCM_OPT_HIGH        2'h2

`endif

/* core/mcm_pkg.sv */
// Types shared by the motor channel manager and its bench
`include "mcm_defs.svh"
package mcm_pkg;

	// Register bus request from the master
	typedef struct packed {
		logic [`MCM_AW-1:0] addr;
		logic [`MCM_DW-1:0] wdata;
		logic               wr;
		logic               rd;
	} mcm_bus_req_t;

	// Step events from the timing and detection logic
	typedef struct packed {
		logic c_ev;
		logic d_ev;
		logic z_ev;
	} mcm_events_t;

	// Step phase, one-hot
	typedef enum logic [2:0] {
		MCM_ST_DEMAG  = 3'b001,
		MCM_ST_WAITZ  = 3'b010,
		MCM_ST_AFTERZ = 3'b100
	} mcm_step_t;

endpackage

/* core/mcm_channel_manager.sv */
// Motor channel manager: phase state, polarity, PWM group routing and emergency stop
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mcm_defs.svh"

// Functional notes
// - Preloaded phase bits move in on C event
// - Polarity and phase bit set channel level
// - Direct access writes the active phase
// - Direct phase write raises internal C event
// - Direct mode uses after-zero select only
// - Enable clear forces reset state, else run
// - Reset state is hi-Z, low or high
// - Group bit 0 high, 1 low channel
// - PWM routed per step phase to groups
// - Demag select preloaded, latched at C event
// - Wait-zero select rules from D to Z
// - After-zero select rules from Z to C
// - Emergency low forces outputs asynchronously
// - Emergency low clears motor output enable
// - Emergency interrupt only when mask bit set
// - Emergency shutdown path needs no clock
// - Output follows instantaneous PWM and state
module mcm_channel_manager (
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	input  wire mcm_pkg::mcm_bus_req_t bus_req,
	output logic [`MCM_DW-1:0]        bus_rdata,
	input  wire mcm_pkg::mcm_events_t step_events,
	input  wire logic                 pwm_in,
	input  wire logic [1:0]           reset_state_opt,
	input  wire logic                 emergency_stop_in_n,
	output logic [`MCM_NCH-1:0]       motor_channel_output,
	output logic [`MCM_NCH-1:0]       motor_channel_oe,
	output logic                      irq
);
	import mcm_pkg::*;

	logic [`MCM_NCH-1:0] phase_state_bits;
	logic [`MCM_NCH-1:0] phase_active;
	logic [`MCM_NCH-1:0] polarity_bits;
	logic [`MCM_NCH-1:0] channel_group_bits;
	logic                motor_output_enable;
	logic                direct_access;
	logic                after_zero_pwm_select;
	logic                wait_zero_pwm_select;
	logic                demag_pwm_select;
	logic                demag_select_active;
	logic [1:0]          int_mask;
	logic [1:0]          int_status;
	logic                emerg_prev;
	mcm_step_t           step;

	logic                wr_phase;
	logic                wr_polarity;
	logic                wr_group;
	logic                wr_ctrl_a;
	logic                wr_ctrl_b;
	logic                wr_mask;
	logic                rd_status;
	logic                c_int;
	logic                emerg_fall;
	logic                next_demag_select;
	logic                pwm_sel;
	logic [1:0]          int_set;

	// Level of one channel while running: phase off gives the inactive level
	function automatic logic channel_level(
		input logic phase,
		input logic pol,
		input logic grp,
		input logic sel,
		input logic pwm
	);
		logic on;
		on = phase & ((grp == sel) ? pwm : 1'b1);
		channel_level = pol ? on : ~on;
	endfunction

	// Write and read decode
	always_comb begin
		wr_phase    = 1'b0;
		wr_polarity = 1'b0;
		wr_group    = 1'b0;
		wr_ctrl_a   = 1'b0;
		wr_ctrl_b   = 1'b0;
		wr_mask     = 1'b0;
		rd_status   = bus_req.rd && (bus_req.addr == `MCM_OFF_INT_STATUS);
		if (!bus_req.wr) begin
			wr_phase = 1'b0;
		end else if (bus_req.addr == `MCM_OFF_PHASE) begin
			wr_phase = 1'b1;
		end else if (bus_req.addr == `MCM_OFF_POLARITY) begin
			wr_polarity = 1'b1;
		end else if (bus_req.addr == `MCM_OFF_GROUP) begin
			wr_group = 1'b1;
		end else if (bus_req.addr == `MCM_OFF_CTRL_A) begin
			wr_ctrl_a = 1'b1;
		end else if (bus_req.addr == `MCM_OFF_CTRL_B) begin
			wr_ctrl_b = 1'b1;
		end else if (bus_req.addr == `MCM_OFF_INT_MASK) begin
			wr_mask = 1'b1;
		end
	end

	// Internal commutation: external C or a direct-mode phase write
	assign c_int      = step_events.c_ev | (wr_phase & direct_access);
	assign emerg_fall = emerg_prev & ~emergency_stop_in_n;
	// Demag select written in the C cycle itself takes effect at once
	assign next_demag_select = wr_ctrl_b ? bus_req.wdata[`MCM_CRB_DEMAG] : demag_pwm_select;
	assign int_set = {c_int, emerg_fall};

	// Preload stage of the phase bits
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			phase_state_bits <= `MCM_RST_PHASE;
		end else if (wr_phase) begin
			phase_state_bits <= bus_req.wdata[`MCM_NCH-1:0];
		end
	end

	// Active phase register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			phase_active <= `MCM_RST_PHASE;
		end else if (wr_phase && direct_access) begin
			phase_active <= bus_req.wdata[`MCM_NCH-1:0];
		end else if (step_events.c_ev) begin
			phase_active <= phase_state_bits;
		end
	end

	// Polarity and group registers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			polarity_bits      <= `MCM_RST_POLARITY;
			channel_group_bits <= `MCM_RST_GROUP;
		end else begin
			if (wr_polarity) begin
				polarity_bits <= bus_req.wdata[`MCM_NCH-1:0];
			end
			if (wr_group) begin
				channel_group_bits <= bus_req.wdata[`MCM_NCH-1:0];
			end
		end
	end

	// Control A; emergency beats a software set of the enable
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			motor_output_enable <= 1'b0;
			direct_access       <= 1'b0;
		end else begin
			if (wr_ctrl_a) begin
				motor_output_enable <= bus_req.wdata[`MCM_CRA_ENABLE];
				direct_access       <= bus_req.wdata[`MCM_CRA_DIRECT];
			end
			if (!emergency_stop_in_n) begin
				motor_output_enable <= 1'b0;
			end
		end
	end

	// Control B and the demag select active copy
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			{demag_pwm_select, wait_zero_pwm_select, after_zero_pwm_select} <= `MCM_RST_OS;
			demag_select_active <= 1'b0;
		end else begin
			if (wr_ctrl_b) begin
				after_zero_pwm_select <= bus_req.wdata[`MCM_CRB_AFTERZ];
				wait_zero_pwm_select  <= bus_req.wdata[`MCM_CRB_WAITZ];
				demag_pwm_select      <= bus_req.wdata[`MCM_CRB_DEMAG];
			end
			if (c_int) begin
				demag_select_active <= next_demag_select;
			end
		end
	end

	// Step phase tracker: C starts demag, D waits for Z, Z runs to next C
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			step <= MCM_ST_AFTERZ;
		end else if (c_int) begin
			step <= MCM_ST_DEMAG;
		end else begin
			case (step)
				MCM_ST_DEMAG: begin
					if (step_events.d_ev) begin
						step <= MCM_ST_WAITZ;
					end
				end
				MCM_ST_WAITZ: begin
					if (step_events.z_ev) begin
						step <= MCM_ST_AFTERZ;
					end
				end
				MCM_ST_AFTERZ: begin
					step <= MCM_ST_AFTERZ;
				end
				default: begin
					step <= MCM_ST_AFTERZ;
				end
			endcase
		end
	end

	// Interrupt mask and sticky status; a set in the clearing read wins
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			int_mask   <= `MCM_RST_INT;
			int_status <= `MCM_RST_INT;
			emerg_prev <= 1'b1;
		end else begin
			emerg_prev <= emergency_stop_in_n;
			if (wr_mask) begin
				int_mask <= bus_req.wdata[1:0];
			end
			int_status <= (rd_status ? `MCM_RST_INT : int_status) | int_set;
		end
	end

	// Emergency line only requests the CPU through its mask bit
	assign irq = |(int_status & int_mask);

	// Read data, valid the cycle after the strobe only
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			bus_rdata <= `MCM_ZERO_DW;
		end else if (!bus_req.rd) begin
			bus_rdata <= `MCM_ZERO_DW;
		end else if (bus_req.addr == `MCM_OFF_PHASE) begin
			bus_rdata <= {2'h0, phase_state_bits};
		end else if (bus_req.addr == `MCM_OFF_POLARITY) begin
			bus_rdata <= {2'h0, polarity_bits};
		end else if (bus_req.addr == `MCM_OFF_GROUP) begin
			bus_rdata <= {2'h0, channel_group_bits};
		end else if (bus_req.addr == `MCM_OFF_CTRL_A) begin
			bus_rdata <= {6'h00, direct_access, motor_output_enable};
		end else if (bus_req.addr == `MCM_OFF_CTRL_B) begin
			bus_rdata <= {5'h00, demag_pwm_select, wait_zero_pwm_select, after_zero_pwm_select};
		end else if (bus_req.addr == `MCM_OFF_INT_MASK) begin
			bus_rdata <= {6'h00, int_mask};
		end else if (bus_req.addr == `MCM_OFF_INT_STATUS) begin
			bus_rdata <= {6'h00, int_status};
		end else if (bus_req.addr == `MCM_OFF_PHASE_ACT) begin
			bus_rdata <= {2'h0, phase_active};
		end else begin
			bus_rdata <= `MCM_ZERO_DW;
		end
	end

	// Group that receives PWM in the current step
	always_comb begin
		if (direct_access) begin
			pwm_sel = after_zero_pwm_select;
		end else begin
			case (step)
				MCM_ST_DEMAG:  pwm_sel = demag_select_active;
				MCM_ST_WAITZ:  pwm_sel = wait_zero_pwm_select;
				MCM_ST_AFTERZ: pwm_sel = after_zero_pwm_select;
				default:       pwm_sel = after_zero_pwm_select;
			endcase
		end
	end

	// Output stage: pure gates from the emergency pin, so no clock is needed
	always_comb begin
		for (int i = 0; i < `MCM_NCH; i++) begin
			if (!emergency_stop_in_n || !motor_output_enable) begin
				case (reset_state_opt)
					`MCM_OPT_LOW: begin
						motor_channel_output[i] = 1'b0;
						motor_channel_oe[i]     = 1'b1;
					end
					`MCM_OPT_HIGH: begin
						motor_channel_output[i] = 1'b1;
						motor_channel_oe[i]     = 1'b1;
					end
					default: begin
						motor_channel_output[i] = 1'b0;
						motor_channel_oe[i]     = 1'b0;
					end
				endcase
			end else begin
				// Live PWM reaches the pin with no register in the way
				motor_channel_output[i] = channel_level(phase_active[i], polarity_bits[i],
					channel_group_bits[i], pwm_sel, pwm_in);
				motor_channel_oe[i]     = 1'b1;
			end
		end
	end

	// Checks
	a_preload_copy: assert property (@(posedge mclk) disable iff (!resetn)
		step_events.c_ev && !(wr_phase && direct_access) |=> phase_active == $past(phase_state_bits))
		else $error("phase preload not copied on C event");

	a_phase_hold: assert property (@(posedge mclk) disable iff (!resetn)
		!c_int |=> $stable(phase_active))
		else $error("active phase changed without C event");

	a_direct_write: assert property (@(posedge mclk) disable iff (!resetn)
		wr_phase && direct_access |=> phase_active == $past(bus_req.wdata[`MCM_NCH-1:0]))
		else $error("direct phase write not applied");

	a_direct_cevent: assert property (@(posedge mclk) disable iff (!resetn)
		wr_phase && direct_access |=> step == MCM_ST_DEMAG)
		else $error("direct write raised no commutation");

	a_polarity_off: assert property (@(posedge mclk) disable iff (!resetn)
		emergency_stop_in_n && motor_output_enable && !phase_active[0]
		|-> motor_channel_output[0] == ~polarity_bits[0] && motor_channel_oe[0])
		else $error("off channel level wrong");

	a_direct_group: assert property (@(posedge mclk) disable iff (!resetn)
		emergency_stop_in_n && motor_output_enable && direct_access && phase_active[0]
		&& channel_group_bits[0] != after_zero_pwm_select
		|-> motor_channel_output[0] == polarity_bits[0])
		else $error("unselected group carried PWM");

	a_emerg_outputs: assert property (@(posedge mclk) disable iff (!resetn)
		!emergency_stop_in_n && reset_state_opt == `MCM_OPT_HIZ |-> motor_channel_oe == 6'h00)
		else $error("emergency did not float outputs");

	a_emerg_enable: assert property (@(posedge mclk) disable iff (!resetn)
		!emergency_stop_in_n |=> !motor_output_enable ##0 int_status[`MCM_INT_EMERG] || !$past(emerg_prev))
		else $error("emergency left output enable set");

	a_emerg_irq: assert property (@(posedge mclk) disable iff (!resetn)
		emerg_fall && int_mask[`MCM_INT_EMERG] && !wr_mask |=> irq)
		else $error("emergency interrupt missing");

	a_waitz_step: assert property (@(posedge mclk) disable iff (!resetn)
		step == MCM_ST_DEMAG && step_events.d_ev && !c_int |=> step == MCM_ST_WAITZ)
		else $error("D event did not enter wait-zero");

	a_demag_latch: assert property (@(posedge mclk) disable iff (!resetn)
		c_int |=> demag_select_active == $past(next_demag_select))
		else $error("demag select not latched at C");

endmodule // mcm_channel_manager
`default_nettype wire

/* dv/mcm_power_stage_model.sv */
// Power stage and alarm source model facing the channel outputs
`timescale 1ns/1ps
`default_nettype none
module mcm_power_stage_model (
	input  wire logic       mclk,
	input  wire logic       alarm,
	input  wire logic [5:0] drive,
	input  wire logic [5:0] drive_en,
	output logic            emergency_stop_in_n,
	output logic [5:0]      pad
);
	logic [5:0] last;

	// Alarm pulls the line low at once, clock or no clock
	assign emergency_stop_in_n = ~alarm;

	// Remember each pad level for the float model
	always_ff @(posedge mclk) begin
		last <= pad;
	end

	// Released pads drift away from their last level, never hold it
	assign pad = (drive & drive_en) | (~last & ~drive_en);
endmodule // mcm_power_stage_model
`default_nettype wire

/* dv/tb_mcm_channel_manager.sv */
// Self-checking bench of the motor channel manager
`timescale 1ns/1ps
`default_nettype none
`include "mcm_defs.svh"
module tb_mcm_channel_manager;
	import mcm_pkg::*;
	logic          mclk, clk_en, resetn, pwm_in, alarm, irq, emergency_stop_in_n;
	mcm_bus_req_t  bus_req;
	mcm_events_t   step_events;
	logic [1:0]    opt;
	logic [7:0]    bus_rdata;
	logic [5:0]    chan_out, chan_oe, pad, e_pol, e_grp, e_ph;
	int            fail_count, comparisons;

	mcm_channel_manager i_mcm_channel_manager (
		.mclk(mclk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.step_events(step_events), .pwm_in(pwm_in), .reset_state_opt(opt),
		.emergency_stop_in_n(emergency_stop_in_n), .motor_channel_output(chan_out),
		.motor_channel_oe(chan_oe), .irq(irq));
	mcm_power_stage_model i_mcm_power_stage_model (
		.mclk(mclk), .alarm(alarm), .drive(chan_out), .drive_en(chan_oe),
		.emergency_stop_in_n(emergency_stop_in_n), .pad(pad));

	// Gated clock so the emergency path can be tried with it stopped
	initial begin
		mclk = 1'b0;
		clk_en = 1'b1;
		forever #20 if (clk_en) mclk = ~mclk;
	end

	task automatic finish_test();
		if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One bus cycle, then an idle cycle
	task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
		@(posedge mclk) bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
		@(posedge mclk) bus_req <= '0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(a, d, 1'b1);
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		bus(a, 8'h00, 1'b0);
		#1 cmp(bus_rdata, exp, "read");
	endtask
	task automatic ev(input logic c, input logic d, input logic z);
		@(posedge mclk) step_events <= '{c_ev: c, d_ev: d, z_ev: z};
		@(posedge mclk) step_events <= '0;
	endtask

	// Undriven channels are masked out of the level compare
	task automatic chk(input logic [5:0] eoe, input logic [5:0] eout);
		cmp({2'h0, chan_oe}, {2'h0, eoe}, "oe");
		cmp({2'h0, chan_out & eoe}, {2'h0, eout & eoe}, "level");
		cmp({2'h0, pad & eoe}, {2'h0, eout & eoe}, "pad");
	endtask
	task automatic chk_rs();
		chk((opt == 2'h1 || opt == 2'h2) ? 6'h3f : 6'h00, (opt == 2'h2) ? 6'h3f : 6'h00);
	endtask

	// Running outputs for both PWM levels under select value s
	task automatic run(input logic s);
		logic [5:0] on;
		for (int p = 0; p < 2; p++) begin
			@(posedge mclk) pwm_in <= p[0];
			#1;
			for (int i = 0; i < 6; i++) begin
				on[i] = e_ph[i] & ((e_grp[i] == s) ? p[0] : 1'b1);
			end
			// Polarity 1 passes the on level, polarity 0 inverts it
			chk(6'h3f, e_pol ~^ on);
		end
	endtask

	initial begin
		#200000;
		fail_count++;
		finish_test();
	end

	initial begin
		resetn = 1'b0;
		bus_req = '0;
		step_events = '0;
		pwm_in = 1'b0;
		alarm = 1'b0;
		opt = 2'h0;
		fail_count = 0;
		comparisons = 0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rd(`MCM_OFF_PHASE, 8'h00);
		rd(`MCM_OFF_PHASE_ACT, 8'h00);
		rd(`MCM_OFF_CTRL_A, 8'h00);
		rd(4'hc, 8'h00);
		// Ends on the high option, which the first emergency check relies on
		for (int o = 0; o < 4; o++) begin
			@(posedge mclk) opt <= o[1:0] + 2'h3;
			#1 chk_rs();
		end
		// Normal run: preload waits for the commutation event
		e_pol = 6'h15;
		e_grp = 6'h38;
		e_ph = 6'h00;
		wr(`MCM_OFF_POLARITY, {2'h0, e_pol});
		wr(`MCM_OFF_GROUP, {2'h0, e_grp});
		wr(`MCM_OFF_CTRL_B, 8'h05);
		rd(`MCM_OFF_POLARITY, {2'h0, e_pol});
		rd(`MCM_OFF_GROUP, {2'h0, e_grp});
		rd(`MCM_OFF_CTRL_B, 8'h05);
		wr(`MCM_OFF_CTRL_A, 8'h01);
		wr(`MCM_OFF_PHASE, 8'h2d);
		rd(`MCM_OFF_PHASE_ACT, 8'h00);
		run(1'b1);
		ev(1'b1, 1'b0, 1'b0);
		e_ph = 6'h2d;
		rd(`MCM_OFF_PHASE_ACT, 8'h2d);
		run(1'b1);
		wr(`MCM_OFF_CTRL_B, 8'h02);
		run(1'b1);
		ev(1'b0, 1'b1, 1'b0);
		run(1'b1);
		ev(1'b0, 1'b0, 1'b1);
		run(1'b0);
		ev(1'b1, 1'b0, 1'b0);
		run(1'b0);
		// Direct access: write lands at once and counts as commutation
		rd(`MCM_OFF_INT_STATUS, 8'h02);
		// After-zero and demag selects differ, so a wrong choice shows
		wr(`MCM_OFF_CTRL_B, 8'h01);
		wr(`MCM_OFF_CTRL_A, 8'h03);
		wr(`MCM_OFF_PHASE, 8'h13);
		e_ph = 6'h13;
		rd(`MCM_OFF_PHASE_ACT, 8'h13);
		run(1'b1);
		rd(`MCM_OFF_INT_STATUS, 8'h02);
		// Emergency with interrupt masked
		wr(`MCM_OFF_CTRL_A, 8'h01);
		@(posedge mclk) alarm <= 1'b1;
		#1 chk_rs();
		@(posedge mclk) #1 cmp({7'h0, irq}, 8'h00, "irq masked");
		rd(`MCM_OFF_CTRL_A, 8'h00);
		rd(`MCM_OFF_INT_STATUS, 8'h01);
		@(posedge mclk) alarm <= 1'b0;
		wr(`MCM_OFF_INT_MASK, 8'h01);
		wr(`MCM_OFF_CTRL_A, 8'h01);
		run(1'b0);
		// Clock stopped, floating option: shutdown must still reach the pins
		@(posedge mclk) opt <= 2'h0;
		@(negedge mclk) clk_en = 1'b0;
		#100 alarm = 1'b1;
		#1 chk_rs();
		#100 clk_en = 1'b1;
		repeat (2) @(posedge mclk);
		#1 cmp({7'h0, irq}, 8'h01, "irq");
		rd(`MCM_OFF_INT_STATUS, 8'h01);
		cmp({7'h0, irq}, 8'h00, "irq clear");
		finish_test();
	end
endmodule // tb_mcm_channel_manager
`default_nettype wire
